// file: verilog/timer_counter_pair.sv
// Two 8-bit up-counting timer/counters with reload, buzzer toggle and PWM outputs.
`timescale 1ns/1ps
module timer_counter_pair #(
    parameter int CPU_DIV = 4
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] busAddr,
    input wire logic [7:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    output logic [7:0] busRdata,
    input wire logic eventInputZero,
    input wire logic eventInputOne,
    output logic toggleOutputZero,
    output logic toggleOutputZeroOe,
    output logic toggleOutputOne,
    output logic toggleOutputOneOe,
    output logic pwmOutZero,
    output logic pwmOutOne,
    output logic overflowIrqZero,
    output logic overflowIrqOne,
    output logic lowpowerWake,
    output logic eventPinIrqZero,
    output logic eventPinIrqOne
);
    tc_pkg::bus_req_t req;
    tc_pkg::mode_t mode [2];
    logic [7:0] count [2];
    logic [7:0] reload [2];
    logic [7:0] shared;
    logic [1:0] irqEnable;
    logic [1:0] irqFlag;
    logic [1:0] toggleState;
    logic [1:0] pwmLevel;
    logic [1:0] pinMeta;
    logic [1:0] pinSync;
    logic [1:0] pinPrev;
    logic [1:0] tick;
    logic [1:0] overflow;
    logic [1:0] eventEdge;
    logic [7:0] oscDiv;
    logic [7:0] cpuDiv;
    logic [7:0] cpuPre;
    logic cpuTick;
    logic [1:0] rateTick;

    assign req = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};

    // Boundary of the count: PWM with reload or toggle set shortens the cycle; otherwise the full byte is used.
    function automatic logic [7:0] boundary(input tc_pkg::mode_t m);
        logic [7:0] top;
        top = tc_pkg::TOP_FULL;
        if (m.pwm) begin
            unique case ({m.reload, m.toggle})
                2'b00: top = tc_pkg::TOP_FULL;
                2'b01: top = tc_pkg::TOP_64;
                2'b10: top = tc_pkg::TOP_32;
                2'b11: top = tc_pkg::TOP_16;
            endcase
        end
        return top;
    endfunction

    // Picks the prescaler tap: divide by 2^(7-rate) from the oscillator or 2^(8-rate) from CPU.
    function automatic logic rate_tick(input logic fast, input logic [2:0] rate,
                                       input logic [7:0] oscCnt, input logic [7:0] cpuCnt,
                                       input logic cpuEn);
        logic [7:0] mask;
        logic hit;
        mask = 8'hFF >> rate;
        if (fast) begin
            hit = ((oscCnt & (mask >> 1)) == (mask >> 1));
        end else begin
            hit = cpuEn && ((cpuCnt & mask) == mask);
        end
        return hit;
    endfunction

    // The CPU clock is a fixed fraction of the oscillator clock.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cpuPre <= 8'h00;
        end else if (cpuPre == 8'(CPU_DIV - 1)) begin
            cpuPre <= 8'h00;
        end else begin
            cpuPre <= cpuPre + 8'h01;
        end
    end

    assign cpuTick = (cpuPre == 8'(CPU_DIV - 1));

    // Free-running oscillator divider; each rate taps its low bits.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            oscDiv <= 8'h00;
        end else begin
            oscDiv <= oscDiv + 8'h01;
        end
    end

    // The CPU divider advances once per CPU clock, so both sources share one clock domain.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cpuDiv <= 8'h00;
        end else if (cpuTick) begin
            cpuDiv <= cpuDiv + 8'h01;
        end
    end

    // Event pins cross into the clock domain through two flip-flops before anything reads them.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pinMeta <= 2'b11;
            pinSync <= 2'b11;
        end else begin
            pinMeta <= {eventInputOne, eventInputZero};
            pinSync <= pinMeta;
        end
    end

    // History starts high like an idle pulled-up pin, so reset release makes no false edge.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pinPrev <= 2'b11;
        end else begin
            pinPrev <= pinSync;
        end
    end

    assign eventEdge = pinPrev & ~pinSync;

    // Internal rate tick of each instance, before the source select.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            rateTick[i] = rate_tick(shared[tc_pkg::SHARED_FAST0_BIT + i], mode[i].rate,
                                    oscDiv, cpuDiv, cpuTick);
        end
    end

    // The event source ignores the fast flag and rate field entirely.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (mode[i].source) begin
                tick[i] = eventEdge[i] & mode[i].run;
            end else begin
                tick[i] = rateTick[i] & mode[i].run;
            end
            overflow[i] = tick[i] && (count[i] == boundary(mode[i]));
        end
    end

    // One write decoder serves every register, so all of them see the same strobe timing.
    function automatic logic write_hit(input tc_pkg::bus_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // Per-instance register addresses, so the loops below can index both timers alike.
    function automatic logic [7:0] mode_addr(input int i);
        return (i == 0) ? tc_pkg::TIMER0_MODE_ADDR : tc_pkg::TIMER1_MODE_ADDR;
    endfunction

    function automatic logic [7:0] count_addr(input int i);
        return (i == 0) ? tc_pkg::TIMER0_COUNT_ADDR : tc_pkg::TIMER1_COUNT_ADDR;
    endfunction

    function automatic logic [7:0] reload_addr(input int i);
        return (i == 0) ? tc_pkg::TIMER0_RELOAD_ADDR : tc_pkg::TIMER1_RELOAD_ADDR;
    endfunction

    // Read multiplexer; the reload registers are write-only and read as zero like unmapped space.
    function automatic logic [7:0] read_mux(input logic [7:0] a, input tc_pkg::mode_t m0,
                                            input tc_pkg::mode_t m1, input logic [7:0] c0,
                                            input logic [7:0] c1, input logic [7:0] sh,
                                            input logic [1:0] flg, input logic [1:0] en);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            tc_pkg::TIMER0_MODE_ADDR: d = m0;
            tc_pkg::TIMER1_MODE_ADDR: d = m1;
            tc_pkg::TIMER0_COUNT_ADDR: d = c0;
            tc_pkg::TIMER1_COUNT_ADDR: d = c1;
            tc_pkg::SHARED_MODE_ADDR: d = sh;
            tc_pkg::IRQ_CTRL_ADDR: d = {2'b00, flg, 2'b00, en};
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    logic [7:0] next_count [2];
    logic [1:0] next_irqFlag;
    logic [7:0] next_rdata;

    // Mode registers: run, rate, source, reload, toggle and PWM bits of each instance.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 2; i++) begin
                mode[i] <= tc_pkg::MODE_RESET;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (write_hit(req, mode_addr(i))) begin
                    mode[i] <= req.wdata;
                end
            end
        end
    end

    // Reload values are only written by software and read by the overflow logic and the PWM compare.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 2; i++) begin
                reload[i] <= tc_pkg::RELOAD_RESET;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (write_hit(req, reload_addr(i))) begin
                    reload[i] <= req.wdata;
                end
            end
        end
    end

    // Next counter value; a software write beats a tick or an overflow in the same cycle.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_count[i] = count[i];
            if (overflow[i] && (mode[i].reload || mode[i].pwm)) begin
                next_count[i] = reload[i];
            end else if (overflow[i]) begin
                next_count[i] = 8'h00;
            end else if (tick[i]) begin
                next_count[i] = count[i] + 8'h01;
            end
            if (write_hit(req, count_addr(i))) begin
                next_count[i] = req.wdata;
            end
        end
    end

    // The counter holds while stopped; only a write or a tick moves it.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 2; i++) begin
                count[i] <= tc_pkg::COUNT_RESET;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                count[i] <= next_count[i];
            end
        end
    end

    // Shared mode register: wake enable and the two fast-clock flags.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            shared <= tc_pkg::SHARED_RESET;
        end else if (write_hit(req, tc_pkg::SHARED_MODE_ADDR)) begin
            shared <= req.wdata;
        end
    end

    // Interrupt enables change only by software.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irqEnable <= 2'b00;
        end else if (write_hit(req, tc_pkg::IRQ_CTRL_ADDR)) begin
            irqEnable <= {req.wdata[tc_pkg::IRQ_EN1_BIT], req.wdata[tc_pkg::IRQ_EN0_BIT]};
        end
    end

    // A new overflow wins over a software clear in the same cycle, so no request is lost.
    always_comb begin
        next_irqFlag = irqFlag;
        if (write_hit(req, tc_pkg::IRQ_CTRL_ADDR)) begin
            next_irqFlag = {req.wdata[tc_pkg::IRQ_FLAG1_BIT],
                            req.wdata[tc_pkg::IRQ_FLAG0_BIT]} & irqFlag;
        end
        next_irqFlag = next_irqFlag | overflow;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irqFlag <= 2'b00;
        end else begin
            irqFlag <= next_irqFlag;
        end
    end

    // Stopping a timer parks its buzzer level low, so a restart always begins from low.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            toggleState <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!mode[i].run) begin
                    toggleState[i] <= 1'b0;
                end else if (overflow[i]) begin
                    toggleState[i] <= ~toggleState[i];
                end
            end
        end
    end

    // PWM stays high until the count reaches the reload value, then low up to the boundary.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pwmLevel <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                pwmLevel[i] <= mode[i].run && mode[i].pwm && (count[i] < reload[i]);
            end
        end
    end

    // Read data stand for exactly one cycle after the strobe and are zero otherwise.
    always_comb begin
        next_rdata = 8'h00;
        if (req.rd) begin
            next_rdata = read_mux(req.addr, mode[0], mode[1], count[0], count[1], shared,
                                  irqFlag, irqEnable);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busRdata <= 8'h00;
        end else begin
            busRdata <= next_rdata;
        end
    end

    // Toggle output owns the pin only while PWM is off; with PWM on the toggle bit only picks the boundary.
    assign toggleOutputZeroOe = mode[0].toggle & ~mode[0].pwm;
    assign toggleOutputOneOe = mode[1].toggle & ~mode[1].pwm;

    // Levels leave straight from flip-flops, so the pins never glitch.
    assign toggleOutputZero = toggleState[0];
    assign toggleOutputOne = toggleState[1];
    assign pwmOutZero = pwmLevel[0];
    assign pwmOutOne = pwmLevel[1];

    // Requests are levels gated by their enables; the flag itself stays visible to software.
    assign overflowIrqZero = irqFlag[0] & irqEnable[0];
    assign overflowIrqOne = irqFlag[1] & irqEnable[1];

    // Wake is a one-cycle pulse per instance-zero overflow; the pin requests vanish in event mode.
    assign lowpowerWake = overflow[0] & shared[tc_pkg::SHARED_WAKE_BIT];
    assign eventPinIrqZero = eventEdge[0] & ~mode[0].source;
    assign eventPinIrqOne = eventEdge[1] & ~mode[1].source;
endmodule

// file: verilog/tc_pkg.sv
// Shared constants and types for the dual 8-bit timer/counter block.
package tc_pkg;
    localparam logic [7:0] TIMER0_MODE_ADDR = 8'hDA;
    localparam logic [7:0] TIMER0_COUNT_ADDR = 8'hDB;
    localparam logic [7:0] TIMER0_RELOAD_ADDR = 8'hCD;
    localparam logic [7:0] TIMER1_MODE_ADDR = 8'hDC;
    localparam logic [7:0] TIMER1_COUNT_ADDR = 8'hDD;
    localparam logic [7:0] TIMER1_RELOAD_ADDR = 8'hDE;
    localparam logic [7:0] SHARED_MODE_ADDR = 8'hD8;
    localparam logic [7:0] IRQ_CTRL_ADDR = 8'hE0;

    localparam int MODE_PWM_BIT = 0;
    localparam int MODE_TOGGLE_BIT = 1;
    localparam int MODE_RELOAD_BIT = 2;
    localparam int MODE_SOURCE_BIT = 3;
    localparam int MODE_RATE_LSB = 4;
    localparam int MODE_RUN_BIT = 7;
    localparam int SHARED_WAKE_BIT = 1;
    localparam int SHARED_FAST0_BIT = 2;
    localparam int SHARED_FAST1_BIT = 3;
    localparam int IRQ_EN0_BIT = 0;
    localparam int IRQ_EN1_BIT = 1;
    localparam int IRQ_FLAG0_BIT = 4;
    localparam int IRQ_FLAG1_BIT = 5;

    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] SHARED_RESET = 8'h00;

    localparam logic [7:0] TOP_FULL = 8'hFF;
    localparam logic [7:0] TOP_64 = 8'h3F;
    localparam logic [7:0] TOP_32 = 8'h1F;
    localparam logic [7:0] TOP_16 = 8'h0F;

    typedef struct packed {
        logic run;
        logic [2:0] rate;
        logic source;
        logic reload;
        logic toggle;
        logic pwm;
    } mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
endpackage

// file: bench/timer_counter_pair_monitor.sv
// Port-level assertions for the dual timer/counter, bound to its top module.
`timescale 1ns/1ps
module timer_counter_pair_monitor (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] busAddr,
    input wire logic [7:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    input wire logic [7:0] busRdata,
    input wire logic toggleOutputZero,
    input wire logic toggleOutputZeroOe,
    input wire logic toggleOutputOneOe,
    input wire logic pwmOutZero,
    input wire logic overflowIrqZero,
    input wire logic lowpowerWake,
    input wire logic eventPinIrqZero
);
    tc_pkg::mode_t m0;
    tc_pkg::mode_t m1;
    logic wake;
    logic en0;
    // Shadows are rebuilt from bus writes alone, so a register that never updates shows up.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            m0 <= '0;
            m1 <= '0;
            wake <= 1'b0;
            en0 <= 1'b0;
        end else if (busWr) begin
            case (busAddr)
                tc_pkg::TIMER0_MODE_ADDR: m0 <= busWdata;
                tc_pkg::TIMER1_MODE_ADDR: m1 <= busWdata;
                tc_pkg::SHARED_MODE_ADDR: wake <= busWdata[tc_pkg::SHARED_WAKE_BIT];
                tc_pkg::IRQ_CTRL_ADDR: en0 <= busWdata[tc_pkg::IRQ_EN0_BIT];
                default: ;
            endcase
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_oe_zero_mode:
        assert property (toggleOutputZeroOe == (m0.toggle && !m0.pwm)) else $error("pin enable 0");
    a_oe_one_mode:
        assert property (toggleOutputOneOe == (m1.toggle && !m1.pwm)) else $error("pin enable 1");
    a_stop_quiets_outs:
        assert property ((!m0.run)[*2] |-> !pwmOutZero && !toggleOutputZero)
            else $error("outputs active while stopped");
    a_pwm_needs_bit:
        assert property (pwmOutZero |-> m0.pwm || $past(m0.pwm)) else $error("pwm without enable");
    a_wake_needs_bit:
        assert property (lowpowerWake |-> wake || $past(wake)) else $error("wake without enable");
    a_wake_one_pulse:
        assert property (lowpowerWake |=> !lowpowerWake) else $error("wake pulse too long");
    a_irq_gated_off:
        assert property (!en0 && !$past(en0) |-> !overflowIrqZero) else $error("irq while disabled");
    a_event_irq_masked:
        assert property (m0.source && $past(m0.source, 2) |-> !eventPinIrqZero)
            else $error("pin irq in event mode");
    a_reload_reads_zero:
        assert property (busRd && busAddr == tc_pkg::TIMER0_RELOAD_ADDR |=> busRdata == 8'h00)
            else $error("reload register readable");
    a_mode_readback:
        assert property (busRd && busAddr == tc_pkg::TIMER1_MODE_ADDR |=> busRdata == $past(m1))
            else $error("mode readback wrong");
endmodule
bind timer_counter_pair timer_counter_pair_monitor timer_counter_pair_monitor_inst (
    .mclk(mclk), .arst_n(arst_n), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
    .busRd(busRd), .busRdata(busRdata), .toggleOutputZero(toggleOutputZero),
    .toggleOutputZeroOe(toggleOutputZeroOe), .toggleOutputOneOe(toggleOutputOneOe),
    .pwmOutZero(pwmOutZero), .overflowIrqZero(overflowIrqZero), .lowpowerWake(lowpowerWake),
    .eventPinIrqZero(eventPinIrqZero));

// file: bench/event_pulse_source.sv
// Behavioural event source that pulls each event pin low for four cycles on request.
`timescale 1ns/1ps
module event_pulse_source (
    input wire logic mclk,
    input wire logic [1:0] fire,
    output logic [1:0] line
);
    logic [2:0] hold [2] = '{3'h0, 3'h0};
    // Pins idle high as a pulled-up input would, so only a request makes a falling edge.
    always @(posedge mclk) begin
        for (int i = 0; i < 2; i++) begin
            if (fire[i]) begin
                hold[i] <= 3'h4;
            end else if (hold[i] != 3'h0) begin
                hold[i] <= hold[i] - 3'h1;
            end
        end
    end
    assign line[0] = (hold[0] == 3'h0);
    assign line[1] = (hold[1] == 3'h0);
endmodule

// file: bench/timer_counter_pair_tb.sv
// Self-checking bench for the dual timer/counter.
`timescale 1ns/1ps
module timer_counter_pair_tb;
    localparam int CPU_DIV = 1;
    localparam logic [7:0] TOPS [4] = '{8'hFF, 8'h3F, 8'h1F, 8'h0F};
    localparam logic [7:0] REGS [9] = '{8'hDA, 8'hDB, 8'hCD, 8'hDC, 8'hDD, 8'hDE, 8'hD8,
        8'hE0, 8'h00};
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] busAddr = 8'h00;
    logic [7:0] busWdata = 8'h00;
    logic busWr = 1'b0;
    logic busRd = 1'b0;
    logic [7:0] busRdata;
    logic [1:0] fire = 2'h0;
    logic [1:0] evt;
    logic tog0, oe0, tog1, oe1, pwm0, pwm1, irq0, irq1, wake, epi0, epi1;
    logic [31:0] seed = 32'h000015ED;
    int n_errors = 0;
    int checked = 0;
    timer_counter_pair #(.CPU_DIV(CPU_DIV)) timer_counter_pair_inst (.mclk(mclk),
        .arst_n(arst_n), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
        .busRd(busRd), .busRdata(busRdata), .eventInputZero(evt[0]), .eventInputOne(evt[1]),
        .toggleOutputZero(tog0), .toggleOutputZeroOe(oe0), .toggleOutputOne(tog1),
        .toggleOutputOneOe(oe1), .pwmOutZero(pwm0), .pwmOutOne(pwm1), .overflowIrqZero(irq0),
        .overflowIrqOne(irq1), .lowpowerWake(wake), .eventPinIrqZero(epi0),
        .eventPinIrqOne(epi1));
    event_pulse_source event_pulse_source_inst (.mclk(mclk), .fire(fire), .line(evt));
    initial begin
        forever #25 mclk = ~mclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Clock cycles between two overflows for a mode byte, fast flag and reload value.
    function automatic logic [15:0] expGap(input logic [7:0] m, input logic f,
        input logic [7:0] r);
        int per;
        int top;
        int st;
        per = f ? (1 << (7 - m[6:4])) : (CPU_DIV << (8 - m[6:4]));
        top = m[0] ? int'(TOPS[m[2:1]]) : 255;
        st = (m[0] || m[2]) ? int'(r) : 0;
        return 16'((top - st + 1) * per);
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        busAddr <= a;
        busWdata <= d;
        busWr <= 1'b1;
        @(posedge mclk);
        busWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge mclk);
        busRd <= 1'b0;
        #1 d = busRdata;
    endtask
    task automatic setup0(input logic [7:0] m, input logic [7:0] sh, input logic [7:0] r);
        wr(tc_pkg::TIMER0_MODE_ADDR, 8'h00);
        wr(tc_pkg::IRQ_CTRL_ADDR, 8'h00);
        wr(tc_pkg::SHARED_MODE_ADDR, sh);
        wr(tc_pkg::TIMER0_COUNT_ADDR, r);
        wr(tc_pkg::TIMER0_RELOAD_ADDR, r);
        wr(tc_pkg::TIMER0_MODE_ADDR, m);
    endtask
    // The wake pulse marks each instance-zero overflow; the first one only aligns the count.
    task automatic gap(output logic [15:0] n, output logic t);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (wake !== 1'b1 && n < 16'd5000);
        t = tog0;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (wake !== 1'b1 && n < 16'd5000);
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // The full sequence needs well under 20000 cycles; twice that means a hang.
    initial begin
        repeat (40000) @(posedge mclk);
        n_errors++;
        print_verdict();
    end
    initial begin
        logic [7:0] d;
        logic [15:0] n;
        logic t;
        logic [7:0] m;
        logic [7:0] r;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        foreach (REGS[i]) begin
            rd(REGS[i], d);
            chk({8'h00, d}, 16'h0000);
        end
        seed = xs(seed);
        wr(tc_pkg::TIMER1_MODE_ADDR, {1'b0, seed[6:0]});
        rd(tc_pkg::TIMER1_MODE_ADDR, d);
        chk({8'h00, d}, {9'h000, seed[6:0]});
        for (int f = 0; f < 2; f++) begin
            for (int k = 0; k < 8; k++) begin
                seed = xs(seed);
                m = 8'h86 | 8'(k << 4);
                r = 8'hF8 | {6'h00, seed[1:0]};
                setup0(m, {5'h00, f[0], 2'h2}, r);
                gap(n, t);
                chk(n, expGap(m, f[0], r));
                chk({15'h0000, tog0 ^ t}, 16'h0001);
                chk({15'h0000, oe0}, 16'h0001);
            end
        end
        for (int k = 0; k < 5; k++) begin
            m = (k == 4) ? 8'hF2 : (8'hF1 | 8'(k << 1));
            setup0(m, 8'h06, 8'h04);
            gap(n, t);
            chk(n, expGap(m, 1'b1, 8'h04));
            chk({15'h0000, oe0}, {15'h0000, m[1] & ~m[0]});
        end
        wr(tc_pkg::IRQ_CTRL_ADDR, 8'h11);
        @(negedge mclk);
        chk({15'h0000, irq0}, 16'h0001);
        wr(tc_pkg::TIMER0_MODE_ADDR, 8'h00);
        wr(tc_pkg::IRQ_CTRL_ADDR, 8'h01);
        @(negedge mclk);
        chk({14'h0000, irq0, tog0 | pwm0}, 16'h0000);
        @(posedge mclk);
        fire <= 2'h1;
        @(posedge mclk);
        fire <= 2'h0;
        t = 1'b0;
        repeat (6) begin
            @(negedge mclk);
            t = t | epi0;
        end
        chk({15'h0000, t}, 16'h0001);
        seed = xs(seed);
        wr(tc_pkg::SHARED_MODE_ADDR, {4'h0, seed[1:0], 2'h0});
        wr(tc_pkg::TIMER0_COUNT_ADDR, 8'h10);
        wr(tc_pkg::TIMER1_COUNT_ADDR, 8'h20);
        wr(tc_pkg::TIMER0_MODE_ADDR, {1'b1, seed[6:4], 4'h8});
        wr(tc_pkg::TIMER1_MODE_ADDR, {1'b1, seed[6:4], 4'h8});
        repeat (3) begin
            @(posedge mclk);
            fire <= 2'h3;
            @(posedge mclk);
            fire <= 2'h0;
            repeat (8) @(posedge mclk);
        end
        rd(tc_pkg::TIMER0_COUNT_ADDR, d);
        chk({8'h00, d}, 16'h0013);
        rd(tc_pkg::TIMER1_COUNT_ADDR, d);
        chk({8'h00, d}, 16'h0023);
        print_verdict();
    end
endmodule
